//--- design/owfr_top.sv
// Top of the output word format registers: register bank and 22-bit word builder
//
// What this block does
// - Each result leaves as a 22-bit word, bits 21..0, shaped by control register.
// - Source select 0 puts conversion result in bits 21..2; 1 puts fixed pattern.
// - Parity disabled drives word bits 1 and 0 to zero.
// - Parity enabled puts even parity of bits 21..2 in bit 1.
// - Bit 0 is even parity of top 4, 8, 12 or 16 bits per span code.
// - Register at 0x14 gives pattern bits 7..0.
// - Register at 0x15 gives pattern bits 15..8.
// - Register at 0x16 bits 3..0 give pattern bits 19..16.
// - Bits 7..4 of control and pattern high registers read zero, not writable.
// - Bits 7..3 of offset calibration register read zero, not writable.
// - Three-bit reference select picks calibration reference; 110 and 111 mean 5.0 V.
`timescale 1ns/1ps
module owfr_top
(
	input  wire logic                                   clk_sys,
	input  wire logic                                   reset,
	input  wire owfr_pkg::owfr_req_type                 req,
	output logic      [7:0]                             rdata_ff,
	input  wire logic                                   result_valid,
	input  wire logic [owfr_pkg::RESULT_WIDTH-1:0]      conversion_result,
	output logic      [owfr_pkg::WORD_WIDTH-1:0]        output_word_ff,
	output logic                                        output_word_valid_ff,
	output owfr_pkg::owfr_ref_type                      ref_select_ff,
	output logic      [2:0]                             ref_code_ff
);

	logic [7:0]                        data_word_control_ff;
	logic [7:0]                        pattern_low_byte_ff;
	logic [7:0]                        pattern_middle_byte_ff;
	logic [7:0]                        pattern_high_nibble_ff;
	logic [7:0]                        offset_calibration_select_ff;
	owfr_pkg::owfr_cfg_type            cfg;
	logic [owfr_pkg::RESULT_WIDTH-1:0] upper_bits;
	logic                              short_span_parity_bit;
	logic                              full_parity_bit;
	logic [owfr_pkg::WORD_WIDTH-1:0]   nxt_output_word;

	owfr_reg_mem u_mem
	(
		.clk_sys                      (clk_sys),
		.reset                        (reset),
		.req                          (req),
		.rdata_ff                     (rdata_ff),
		.data_word_control_ff         (data_word_control_ff),
		.pattern_low_byte_ff          (pattern_low_byte_ff),
		.pattern_middle_byte_ff       (pattern_middle_byte_ff),
		.pattern_high_nibble_ff       (pattern_high_nibble_ff),
		.offset_calibration_select_ff (offset_calibration_select_ff)
	);

	// ****************************************************************
	// Even parity over the top n bits of the 20-bit field
	// ****************************************************************
	function automatic logic top_parity(input logic [19:0] v, input owfr_pkg::owfr_span_type s);
		logic p;
		p = 1'b0;
		case (s)
			owfr_pkg::OWFR_SPAN_4:  p = ^v[19:16];
			owfr_pkg::OWFR_SPAN_8:  p = ^v[19:12];
			owfr_pkg::OWFR_SPAN_12: p = ^v[19:8];
			owfr_pkg::OWFR_SPAN_16: p = ^v[19:4];
			default:                p = 1'b0;
		endcase
		return p;
	endfunction

	// ****************************************************************
	// Word assembly
	// ****************************************************************
	always_comb
	begin
		cfg.data_source_select       = data_word_control_ff[owfr_pkg::BIT_DATA_SOURCE_SELECT];
		cfg.parity_append_enable     = data_word_control_ff[owfr_pkg::BIT_PARITY_APPEND_ENABLE];
		cfg.short_parity_span_select = owfr_pkg::owfr_span_type'(
			data_word_control_ff[owfr_pkg::POS_SPAN_SELECT +: 2]);
		cfg.fixed_output_pattern     = {pattern_high_nibble_ff[3:0],
			pattern_middle_byte_ff,
			pattern_low_byte_ff};
	end

	always_comb
	begin
		upper_bits = cfg.data_source_select ? cfg.fixed_output_pattern : conversion_result;
		full_parity_bit       = ^upper_bits;
		short_span_parity_bit = top_parity(upper_bits, cfg.short_parity_span_select);
		if (cfg.parity_append_enable)
			nxt_output_word = {upper_bits, full_parity_bit, short_span_parity_bit};
		else
			nxt_output_word = {upper_bits, 2'b00};
	end

	// Settings are sampled when the word is built, so a write lands on the next word
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			output_word_ff <= '0;
		else if (result_valid)
			output_word_ff <= nxt_output_word;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			output_word_valid_ff <= 1'b0;
		else
			output_word_valid_ff <= result_valid;
	end

	// ****************************************************************
	// Offset calibration reference
	// ****************************************************************
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			ref_select_ff <= owfr_pkg::OWFR_REF_5V0;
			ref_code_ff   <= 3'h0;
		end
		else
		begin
			ref_code_ff <= offset_calibration_select_ff[2:0];
			case (offset_calibration_select_ff[2:0])
				3'h6, 3'h7: ref_select_ff <= owfr_pkg::OWFR_REF_5V0;
				default:    ref_select_ff <= owfr_pkg::owfr_ref_type'(
					offset_calibration_select_ff[2:0]);
			endcase
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	no_parity_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
		(result_valid && !data_word_control_ff[1]) |=> (output_word_ff[1:0] == 2'b00))
		else $error("parity bits not zero while parity off");
	full_parity_a: assert property (@(posedge clk_sys) disable iff (reset)
		(result_valid && data_word_control_ff[1]) |=> !(^output_word_ff[21:1]))
		else $error("full parity bit wrong");
	short_parity_a: assert property (@(posedge clk_sys) disable iff (reset)
		(result_valid && data_word_control_ff[1] && data_word_control_ff[3:2] == 2'h1)
		|=> (output_word_ff[0] == ^output_word_ff[21:14]))
		else $error("short span parity wrong");
	result_source_a: assert property (@(posedge clk_sys) disable iff (reset)
		(result_valid && !data_word_control_ff[0])
		|=> (output_word_ff[21:2] == $past(conversion_result)))
		else $error("result not passed through");
	pattern_source_a: assert property (@(posedge clk_sys) disable iff (reset)
		(result_valid && data_word_control_ff[0]) |=> (output_word_ff[21:2] ==
		{$past(pattern_high_nibble_ff[3:0]), $past(pattern_middle_byte_ff),
		$past(pattern_low_byte_ff)}))
		else $error("pattern not output");
	reserved_ctrl_a: assert property (@(posedge clk_sys) disable iff (reset)
		(req.rd_en && (req.addr == owfr_pkg::ADDR_DATA_WORD_CONTROL ||
		req.addr == owfr_pkg::ADDR_PATTERN_HIGH_NIBBLE)) |=> (rdata_ff[7:4] == 4'h0))
		else $error("reserved bits set");
	reserved_cal_a: assert property (@(posedge clk_sys) disable iff (reset)
		(req.rd_en && req.addr == owfr_pkg::ADDR_OFFSET_CALIBRATION_SEL) |=> (rdata_ff[7:3] == 5'h00))
		else $error("calibration reserved bits nonzero");
	ref_alias_a: assert property (@(posedge clk_sys) disable iff (reset)
		(offset_calibration_select_ff[2:1] == 2'h3) |=> (ref_select_ff == owfr_pkg::OWFR_REF_5V0))
		else $error("alias code not 5.0 V");
	next_word_a: assert property (@(posedge clk_sys) disable iff (reset)
		(req.wr_en && req.addr == owfr_pkg::ADDR_DATA_WORD_CONTROL && req.wdata[1:0] == 2'h0)
		##1 result_valid |=> (output_word_ff[1:0] == 2'b00))
		else $error("setting not applied to next word");

endmodule

//--- design/owfr_pkg.sv
// Package: register map, field layout and types of the output word format registers
package owfr_pkg;

	localparam logic [7:0] ADDR_DATA_WORD_CONTROL       = 8'h10;
	localparam logic [7:0] ADDR_PATTERN_LOW_BYTE        = 8'h14;
	localparam logic [7:0] ADDR_PATTERN_MIDDLE_BYTE     = 8'h15;
	localparam logic [7:0] ADDR_PATTERN_HIGH_NIBBLE     = 8'h16;
	localparam logic [7:0] ADDR_OFFSET_CALIBRATION_SEL  = 8'h20;

	localparam logic [7:0] RESET_REG                    = 8'h00;

	localparam int         BIT_DATA_SOURCE_SELECT       = 0;
	localparam int         BIT_PARITY_APPEND_ENABLE     = 1;
	localparam int         POS_SPAN_SELECT              = 2;
	localparam int         RESULT_WIDTH                 = 20;
	localparam int         WORD_WIDTH                   = 22;
	localparam int         REG_COUNT                    = 5;

	typedef enum logic [1:0]
	{
		OWFR_SPAN_4  = 2'h0,
		OWFR_SPAN_8  = 2'h1,
		OWFR_SPAN_12 = 2'h2,
		OWFR_SPAN_16 = 2'h3
	} owfr_span_type;

	typedef enum logic [2:0]
	{
		OWFR_REF_5V0   = 3'h0,
		OWFR_REF_4V5   = 3'h1,
		OWFR_REF_4V096 = 3'h2,
		OWFR_REF_3V3   = 3'h3,
		OWFR_REF_3V0   = 3'h4,
		OWFR_REF_2V5   = 3'h5,
		OWFR_REF_5V0_B = 3'h6,
		OWFR_REF_5V0_C = 3'h7
	} owfr_ref_type;

	// Register bus request as seen from the serial interface
	typedef struct packed
	{
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} owfr_req_type;

	// Decoded format settings used by the word builder
	typedef struct packed
	{
		logic                  data_source_select;
		logic                  parity_append_enable;
		owfr_span_type         short_parity_span_select;
		logic [RESULT_WIDTH-1:0] fixed_output_pattern;
	} owfr_cfg_type;

endpackage

//--- design/owfr_reg_mem.sv
// Register storage of the output word format block, registered read data
`timescale 1ns/1ps
module owfr_reg_mem
(
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire owfr_pkg::owfr_req_type req,
	output logic      [7:0]            rdata_ff,
	output logic      [7:0]            data_word_control_ff,
	output logic      [7:0]            pattern_low_byte_ff,
	output logic      [7:0]            pattern_middle_byte_ff,
	output logic      [7:0]            pattern_high_nibble_ff,
	output logic      [7:0]            offset_calibration_select_ff
);

	// ****************************************************************
	// Writes; read-only bits are never stored
	// ****************************************************************
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			data_word_control_ff         <= owfr_pkg::RESET_REG;
			pattern_low_byte_ff          <= owfr_pkg::RESET_REG;
			pattern_middle_byte_ff       <= owfr_pkg::RESET_REG;
			pattern_high_nibble_ff       <= owfr_pkg::RESET_REG;
			offset_calibration_select_ff <= owfr_pkg::RESET_REG;
		end
		else if (req.wr_en)
		begin
			case (req.addr)
				owfr_pkg::ADDR_DATA_WORD_CONTROL:
					data_word_control_ff <= {4'h0, req.wdata[3:0]};
				owfr_pkg::ADDR_PATTERN_LOW_BYTE:
					pattern_low_byte_ff <= req.wdata;
				owfr_pkg::ADDR_PATTERN_MIDDLE_BYTE:
					pattern_middle_byte_ff <= req.wdata;
				owfr_pkg::ADDR_PATTERN_HIGH_NIBBLE:
					pattern_high_nibble_ff <= {4'h0, req.wdata[3:0]};
				owfr_pkg::ADDR_OFFSET_CALIBRATION_SEL:
					offset_calibration_select_ff <= {5'h00, req.wdata[2:0]};
				default:
					;
			endcase
		end
	end

	// ****************************************************************
	// Registered read; unmapped addresses read zero
	// ****************************************************************
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			rdata_ff <= owfr_pkg::RESET_REG;
		else if (req.rd_en)
		begin
			case (req.addr)
				owfr_pkg::ADDR_DATA_WORD_CONTROL:      rdata_ff <= data_word_control_ff;
				owfr_pkg::ADDR_PATTERN_LOW_BYTE:       rdata_ff <= pattern_low_byte_ff;
				owfr_pkg::ADDR_PATTERN_MIDDLE_BYTE:    rdata_ff <= pattern_middle_byte_ff;
				owfr_pkg::ADDR_PATTERN_HIGH_NIBBLE:    rdata_ff <= pattern_high_nibble_ff;
				owfr_pkg::ADDR_OFFSET_CALIBRATION_SEL: rdata_ff <= offset_calibration_select_ff;
				default:                               rdata_ff <= 8'h00;
			endcase
		end
	end

endmodule

//--- tb/owfr_host_model.sv
// Host side model: register requests and conversion results toward the block
`timescale 1ns/1ps
module owfr_host_model
(
	input  wire logic                         clk_sys,
	input  wire logic [7:0]                   rdata_ff,
	output owfr_pkg::owfr_req_type            req,
	output logic                              result_valid,
	output logic [owfr_pkg::RESULT_WIDTH-1:0] conversion_result
);
	initial
	begin
		req = '0;
		result_valid = 1'b0;
		conversion_result = '0;
	end

	// Request held from just after one edge until just after the taking edge
	task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_sys);
		#1 req = '{wr_en: 1'b1, rd_en: 1'b0, addr: addr, wdata: data};
		@(posedge clk_sys);
		#1 req = '{wr_en: 1'b0, rd_en: 1'b0, addr: addr, wdata: ~data};
	endtask

	task automatic reg_rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_sys);
		#1 req = '{wr_en: 1'b0, rd_en: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge clk_sys);
		#1 req.rd_en = 1'b0;
		data = rdata_ff;
	endtask

	// Released result lines show the inverse, never a stale copy
	task automatic send_result(input logic [owfr_pkg::RESULT_WIDTH-1:0] r);
		@(posedge clk_sys);
		#1 result_valid = 1'b1;
		conversion_result = r;
		@(posedge clk_sys);
		#1 result_valid = 1'b0;
		conversion_result = ~r;
	endtask
endmodule

//--- tb/tb_output_word_format_regs.sv
// Testbench of the output word format registers
`timescale 1ns/1ps
module tb_output_word_format_regs;
	logic                   clk_sys;
	logic                   reset;
	owfr_pkg::owfr_req_type req;
	logic [7:0]             rdata_ff;
	logic                   result_valid;
	logic [19:0]            conversion_result;
	logic [21:0]            output_word_ff;
	logic                   output_word_valid_ff;
	owfr_pkg::owfr_ref_type ref_select_ff;
	logic [2:0]             ref_code_ff;
	int                     fails;
	int                     checks;
	logic [7:0]             rd;

	owfr_top i_dut (.clk_sys(clk_sys), .reset(reset), .req(req), .rdata_ff(rdata_ff),
		.result_valid(result_valid), .conversion_result(conversion_result),
		.output_word_ff(output_word_ff), .output_word_valid_ff(output_word_valid_ff),
		.ref_select_ff(ref_select_ff), .ref_code_ff(ref_code_ff));
	owfr_host_model i_host (.clk_sys(clk_sys), .rdata_ff(rdata_ff), .req(req),
		.result_valid(result_valid), .conversion_result(conversion_result));

	task automatic check(input string name, input logic [21:0] seen, input logic [21:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict;
		$display("Checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [21:0] exp_word(input logic [19:0] r, input int span);
		return {r, ^r, ^(r >> (16 - 4 * span))};
	endfunction

	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		i_host.reg_rd(addr, rd);
		check("rdata", 22'(rd), 22'(exp));
	endtask

	task automatic word_chk(input logic [19:0] r, input logic [21:0] exp);
		i_host.send_result(r);
		check("word_valid", 22'(output_word_valid_ff), 22'h1);
		check("word", output_word_ff, exp);
		@(posedge clk_sys);
		#1 check("word_valid_drop", 22'(output_word_valid_ff), 22'h0);
	endtask

	// Reset values, then all ones written: reserved bits stay zero
	task automatic t_registers;
		logic [7:0] addrs [6] = '{8'h10, 8'h14, 8'h15, 8'h16, 8'h20, 8'h30};
		logic [7:0] full [6] = '{8'h0f, 8'hff, 8'hff, 8'h0f, 8'h07, 8'h00};
		foreach (addrs[i])
			rd_chk(addrs[i], 8'h00);
		foreach (addrs[i])
			i_host.reg_wr(addrs[i], 8'hff);
		foreach (addrs[i])
			rd_chk(addrs[i], full[i]);
	endtask

	task automatic t_pattern;
		i_host.reg_wr(8'h10, 8'h01);
		i_host.reg_wr(8'h14, 8'h3e);
		i_host.reg_wr(8'h15, 8'h5c);
		i_host.reg_wr(8'h16, 8'hfa);
		word_chk(20'h12345, {20'ha5c3e, 2'b00});
		i_host.reg_wr(8'h10, 8'h00);
		word_chk(20'h12345, {20'h12345, 2'b00});
	endtask

	// All four span codes stepped; result 84210 picked so the short parity alternates between codes
	task automatic t_parity;
		for (int s = 0; s < 4; s++)
		begin
			i_host.reg_wr(8'h10, 8'(s * 4 + 2));
			word_chk(20'h84210, exp_word(20'h84210, s));
			word_chk(20'h00007, exp_word(20'h00007, s));
		end
	endtask

	task automatic t_next_word;
		fork
			i_host.reg_wr(8'h10, 8'h01);
			i_host.send_result(20'h84210);
		join
		check("word_old_cfg", output_word_ff, exp_word(20'h84210, 3));
		word_chk(20'h0f0f0, {20'ha5c3e, 2'b00});
		// Result one cycle after the write must already see parity off
		i_host.reg_wr(8'h10, 8'h02);
		fork
			i_host.reg_wr(8'h10, 8'h00);
			begin
				@(posedge clk_sys);
				i_host.send_result(20'h84211);
			end
		join
		check("word_new_cfg", output_word_ff, {20'h84211, 2'b00});
	endtask

	task automatic t_reference;
		for (int c = 0; c < 8; c++)
		begin
			i_host.reg_wr(8'h20, 8'(c));
			@(posedge clk_sys);
			#1 check("ref_code", 22'(ref_code_ff), 22'(c));
			check("ref_select", 22'(ref_select_ff), 22'(c > 5 ? 0 : c));
		end
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial
	begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		print_verdict();
	end

	initial
	begin
		fails = 0;
		checks = 0;
		reset = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1 reset = 1'b0;
		t_registers();
		t_pattern();
		t_parity();
		t_next_word();
		t_reference();
		print_verdict();
	end
endmodule
